//--- logic/mrfc_pkg.sv
// Constants shared by the modem rate and format configuration bank
package mrfc_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0]  MRFC_IDX_EXPONENT  = 8'h10;
  localparam logic [7:0]  MRFC_IDX_MANTISSA  = 8'h11;
  localparam logic [7:0]  MRFC_IDX_MODCTRL   = 8'h12;
  localparam logic [9:0]  MRFC_ADDR_EXPONENT = {MRFC_IDX_EXPONENT, 2'h0};
  localparam logic [9:0]  MRFC_ADDR_MANTISSA = {MRFC_IDX_MANTISSA, 2'h0};
  localparam logic [9:0]  MRFC_ADDR_MODCTRL  = {MRFC_IDX_MODCTRL, 2'h0};

  // Field positions
  localparam int          MRFC_EXP_LSB       = 0;
  localparam int          MRFC_EXP_MSB       = 3;
  localparam int          MRFC_MANT_LSB      = 0;
  localparam int          MRFC_MANT_MSB      = 7;
  localparam int          MRFC_DCBYP_BIT     = 7;
  localparam int          MRFC_MODSEL_LSB    = 4;
  localparam int          MRFC_MODSEL_MSB    = 6;
  localparam int          MRFC_BIPHASE_BIT   = 3;

  // Reset values
  localparam logic [3:0]  MRFC_EXP_RST       = 4'hC;
  localparam logic [7:0]  MRFC_MANT_RST      = 8'h22;
  localparam logic        MRFC_DCBYP_RST     = 1'b0;
  localparam logic [2:0]  MRFC_MODSEL_RST    = 3'h0;
  localparam logic        MRFC_BIPHASE_RST   = 1'b0;

  // Rate arithmetic: hidden leading one and fraction width of the accumulator
  localparam logic [8:0]  MRFC_HIDDEN_ONE    = 9'h100;
  localparam int          MRFC_RATE_FRAC_W   = 28;
  localparam int          MRFC_RATE_WORD_W   = 24;

  // AHB-Lite transfer codes
  localparam logic [1:0]  MRFC_HTRANS_NONSEQ = 2'h2;
  localparam logic        MRFC_HRESP_OKAY    = 1'b0;

  typedef enum logic [2:0] {
    MRFC_MOD_2FSK = 3'b000,
    MRFC_MOD_GFSK = 3'b001,
    MRFC_MOD_OOK  = 3'b011,
    MRFC_MOD_MSK  = 3'b111
  } mrfc_mod_t;

endpackage

//--- logic/mrfc_rate_acc.sv
// Phase accumulator turning the symbol rate word into a symbol strobe
`timescale 1ns/1ps
`default_nettype none
module mrfc_rate_acc #(
  parameter int ACC_W  = 28,
  parameter int WORD_W = 24
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic [WORD_W-1:0] rate_word,
  output logic                   symbol_tick
);

  if (WORD_W >= ACC_W) begin : g_bad_width
    $error("mrfc_rate_acc: WORD_W must be below ACC_W");
  end

  logic [ACC_W-1:0] acc_ff;
  logic [ACC_W:0]   acc_sum;
  logic             tick_ff;

  // The carry out of the fraction divides the word by two to the ACC_W
  assign acc_sum     = {1'b0, acc_ff} + {{(ACC_W+1-WORD_W){1'b0}}, rate_word};
  assign symbol_tick = tick_ff;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      acc_ff  <= acc_sum[ACC_W-1:0];
      tick_ff <= acc_sum[ACC_W];
    end
  end

endmodule // mrfc_rate_acc
`default_nettype wire

//--- logic/mrfc_config.sv
// Modem symbol rate and modulation format register bank on AHB-Lite
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module mrfc_config
  import mrfc_pkg::*;
#(
  parameter int RATE_FRAC_W = MRFC_RATE_FRAC_W
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic [7:0]       rate_mantissa,
  output logic [3:0]       rate_exponent,
  output logic [23:0]      symbol_rate_word,
  output logic             symbol_tick,
  output logic             dc_block_bypass,
  output logic [2:0]       modulation_select,
  output logic             modulation_defined,
  output logic             mod_fsk2,
  output logic             mod_gfsk,
  output logic             mod_ook,
  output logic             mod_msk,
  output logic             biphase_enable
);

  if (RATE_FRAC_W <= MRFC_RATE_WORD_W) begin : g_bad_frac
    $error("mrfc_config: RATE_FRAC_W must exceed the rate word width");
  end

  logic [3:0]  exp_ff;
  logic [7:0]  mant_ff;
  logic        dcbyp_ff;
  logic [2:0]  modsel_ff;
  logic        biphase_ff;
  logic        wr_pend_ff;
  logic [9:0]  wr_addr_ff;
  logic [31:0] rdata_ff;
  logic [23:0] rate_word_ff;
  logic [4:0]  mod_dec_ff;

  logic [3:0]  nxt_exp;
  logic [7:0]  nxt_mant;
  logic        nxt_dcbyp;
  logic [2:0]  nxt_modsel;
  logic        nxt_biphase;
  logic [31:0] nxt_rdata;
  logic [23:0] nxt_rate_word;

  // Address phase decode
  wire         addr_phase = hsel & hready & (htrans == MRFC_HTRANS_NONSEQ | htrans == 2'h3);
  wire         in_window  = (haddr[31:10] == 22'h0);
  wire         lane0      = (haddr[1:0] == 2'h0);
  wire         take_wr    = addr_phase & hwrite & in_window & lane0;
  wire         take_rd    = addr_phase & ~hwrite;

  // Data phase write strobes
  wire         wr_exp     = wr_pend_ff & (wr_addr_ff == MRFC_ADDR_EXPONENT);
  wire         wr_mant    = wr_pend_ff & (wr_addr_ff == MRFC_ADDR_MANTISSA);
  wire         wr_mod     = wr_pend_ff & (wr_addr_ff == MRFC_ADDR_MODCTRL);

  assign nxt_exp     = wr_exp ? hwdata[MRFC_EXP_MSB:MRFC_EXP_LSB] : exp_ff;
  assign nxt_mant    = wr_mant ? hwdata[MRFC_MANT_MSB:MRFC_MANT_LSB] : mant_ff;
  assign nxt_dcbyp   = wr_mod ? hwdata[MRFC_DCBYP_BIT] : dcbyp_ff;
  assign nxt_modsel  = wr_mod ? hwdata[MRFC_MODSEL_MSB:MRFC_MODSEL_LSB] : modsel_ff;
  assign nxt_biphase = wr_mod ? hwdata[MRFC_BIPHASE_BIT] : biphase_ff;

  // Read data is built from next values so a read right after a write sees it
  wire [31:0]  rd_exp     = {28'h0, nxt_exp};
  wire [31:0]  rd_mant    = {24'h0, nxt_mant};
  wire [31:0]  rd_mod     = {24'h0, nxt_dcbyp, nxt_modsel, nxt_biphase, 3'h0};
  wire         hit_exp    = (haddr[31:0] == {22'h0, MRFC_ADDR_EXPONENT});
  wire         hit_mant   = (haddr[31:0] == {22'h0, MRFC_ADDR_MANTISSA});
  wire         hit_mod    = (haddr[31:0] == {22'h0, MRFC_ADDR_MODCTRL});
  assign nxt_rdata = !take_rd ? 32'h0 :
                     hit_exp  ? rd_exp :
                     hit_mant ? rd_mant :
                     hit_mod  ? rd_mod : 32'h0;

  // Hidden one above the mantissa, shifted by the exponent
  wire [23:0]  mant_ext   = {15'h0, MRFC_HIDDEN_ONE | {1'b0, mant_ff}};
  assign nxt_rate_word = mant_ext << exp_ff;

  // Modulation decode; unassigned codes leave every format line low
  wire         dec_fsk2   = (modsel_ff == MRFC_MOD_2FSK);
  wire         dec_gfsk   = (modsel_ff == MRFC_MOD_GFSK);
  wire         dec_ook    = (modsel_ff == MRFC_MOD_OOK);
  wire         dec_msk    = (modsel_ff == MRFC_MOD_MSK);
  wire         dec_any    = dec_fsk2 | dec_gfsk | dec_ook | dec_msk;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      exp_ff     <= MRFC_EXP_RST;
      mant_ff    <= MRFC_MANT_RST;
      dcbyp_ff   <= MRFC_DCBYP_RST;
      modsel_ff  <= MRFC_MODSEL_RST;
      biphase_ff <= MRFC_BIPHASE_RST;
    end else begin
      exp_ff     <= nxt_exp;
      mant_ff    <= nxt_mant;
      dcbyp_ff   <= nxt_dcbyp;
      modsel_ff  <= nxt_modsel;
      biphase_ff <= nxt_biphase;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 10'h0;
      rdata_ff   <= 32'h0;
    end else begin
      wr_pend_ff <= take_wr;
      wr_addr_ff <= haddr[9:0];
      rdata_ff   <= nxt_rdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rate_word_ff <= 24'h0;
      mod_dec_ff   <= 5'h0;
    end else begin
      rate_word_ff <= nxt_rate_word;
      mod_dec_ff   <= {dec_any, dec_fsk2, dec_gfsk, dec_ook, dec_msk};
    end
  end

  // Symbol strobe at the rate word over two to the RATE_FRAC_W times the clk_sys rate; the crystal scale is the clock itself
  mrfc_rate_acc #(
    .ACC_W  (RATE_FRAC_W),
    .WORD_W (MRFC_RATE_WORD_W)
  ) u_rate_acc (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .rate_word   (rate_word_ff),
    .symbol_tick (symbol_tick)
  );

  // Zero wait state slave, always OKAY
  assign hreadyout          = 1'b1;
  assign hresp              = MRFC_HRESP_OKAY;
  assign hrdata             = rdata_ff;
  assign rate_mantissa      = mant_ff;
  assign rate_exponent      = exp_ff;
  assign symbol_rate_word   = rate_word_ff;
  // Bypass saves current; only usable at low data rates, software keeps it so
  assign dc_block_bypass    = dcbyp_ff;
  assign modulation_select  = modsel_ff;
  assign modulation_defined = mod_dec_ff[4];
  assign mod_fsk2           = mod_dec_ff[3];
  assign mod_gfsk           = mod_dec_ff[2];
  assign mod_ook            = mod_dec_ff[1];
  assign mod_msk            = mod_dec_ff[0];
  assign biphase_enable     = biphase_ff;

  AST_MANT_RESET: assert property (@(posedge clk_sys)
    $fell(sys_rst) |-> rate_mantissa == 8'h22 && rate_exponent == 4'hC)
    else $error("Mantissa or exponent wrong after reset");

  AST_MANT_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_mant |=> rate_mantissa == $past(hwdata[7:0]))
    else $error("Mantissa write not stored");

  AST_EXP_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_exp |=> rate_exponent == $past(hwdata[3:0])
      ##1 ($past(wr_exp) || rate_exponent == $past(hwdata[3:0], 2)))
    else $error("Exponent write not stored");

  AST_RATE_WORD: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !sys_rst |=> symbol_rate_word == (24'({1'b1, $past(rate_mantissa)}) << $past(rate_exponent)))
    else $error("Rate word does not follow mantissa and exponent");

  AST_DCBYP: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_mod |=> dc_block_bypass == $past(hwdata[7]))
    else $error("Bypass bit not taken from write");

  AST_MODSEL: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_mod && hwdata[6:4] == 3'b011 |-> ##2 mod_ook && !mod_fsk2 && !mod_msk && !mod_gfsk)
    else $error("OOK code not decoded");

  AST_MOD_UNDEF: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !sys_rst |=> modulation_defined ==
      ($past(modulation_select) inside {3'b000, 3'b001, 3'b011, 3'b111}))
    else $error("Defined flag does not match the format code");

  AST_BIPHASE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !wr_mod |=> $stable(biphase_enable))
    else $error("Biphase bit changed without a write");

  AST_READBACK: assert property (@(posedge clk_sys) disable iff (sys_rst)
    take_rd && hit_mant |=> hrdata == {24'h0, rate_mantissa})
    else $error("Mantissa readback mismatch");

  AST_RDATA_IDLE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !take_rd |=> hrdata == 32'h0)
    else $error("Read data not cleared outside a data phase");

  AST_MODSEL_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_mod |=> modulation_select == $past(hwdata[6:4]))
    else $error("Modulation code not taken from write");

  AST_BIPHASE_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_mod |=> biphase_enable == $past(hwdata[3]))
    else $error("Biphase bit not taken from write");

  AST_DCBYP_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !wr_mod |=> $stable(dc_block_bypass))
    else $error("Bypass bit changed without a write");

endmodule // mrfc_config
`default_nettype wire

//--- verification/mrfc_config_tb.sv
// Self-checking bench for the modem rate and format register bank
`timescale 1ns/1ps
`default_nettype none
module mrfc_config_tb
  import mrfc_pkg::*;
;
  localparam int FRAC_W = 25;
  logic              clk_sys = 1'b0;
  logic              sys_rst = 1'b1;
  logic              hsel = 1'b0;
  logic [31:0]       haddr = 32'h0;
  logic [1:0]        htrans = 2'h0;
  logic              hwrite = 1'b0;
  logic [2:0]        hsize = 3'h2;
  logic [31:0]       hwdata = 32'h0;
  logic              hreadyout, hresp, symbol_tick, dc_block_bypass, modulation_defined;
  logic              mod_fsk2, mod_gfsk, mod_ook, mod_msk, biphase_enable;
  logic [31:0]       hrdata;
  logic [7:0]        rate_mantissa;
  logic [3:0]        rate_exponent;
  logic [23:0]       symbol_rate_word;
  logic [2:0]        modulation_select;
  logic [31:0]       exp_q[$];
  logic              dph_rd = 1'b0;
  logic [7:0]        rnd = 8'h0E;
  int                mismatches = 0;
  int                checked = 0;

  always #12.5 clk_sys = ~clk_sys;

  mrfc_config #(.RATE_FRAC_W(FRAC_W)) u_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rate_mantissa(rate_mantissa),
    .rate_exponent(rate_exponent), .symbol_rate_word(symbol_rate_word),
    .symbol_tick(symbol_tick), .dc_block_bypass(dc_block_bypass),
    .modulation_select(modulation_select), .modulation_defined(modulation_defined),
    .mod_fsk2(mod_fsk2), .mod_gfsk(mod_gfsk), .mod_ook(mod_ook), .mod_msk(mod_msk),
    .biphase_enable(biphase_enable));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wait_rdy();
    do begin
      @(posedge clk_sys);
    end while (hreadyout !== 1'b1);
  endtask

  // One single transfer; a read leaves its expected word for the monitor
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input logic [31:0] exp);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= MRFC_HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    if (!wr) exp_q.push_back(exp);
    wait_rdy();
  endtask

  // Read data is judged at the edge that ends its data phase
  always @(posedge clk_sys) begin
    if (dph_rd && hreadyout === 1'b1) chk("hrdata", hrdata, exp_q.pop_front());
    if (hreadyout === 1'b1) dph_rd <= hsel && htrans[1] && !hwrite;
    if (hresp !== MRFC_HRESP_OKAY) chk("hresp", hresp, MRFC_HRESP_OKAY);
  end

  task automatic settle();
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    bus(1'b0, 32'(MRFC_ADDR_EXPONENT), 32'h0, 32'h0000_000C);
    bus(1'b0, 32'(MRFC_ADDR_MANTISSA), 32'h0, 32'h0000_0022);
    bus(1'b0, 32'(MRFC_ADDR_MODCTRL), 32'h0, 32'h0000_0000);
    @(negedge clk_sys);
    chk("word_rst", symbol_rate_word, 32'h0012_2000);
    chk("fsk2_rst", {mod_fsk2, modulation_defined}, 32'h3);
  endtask

  task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    wrap_up();
  end

  initial begin
    logic [7:0]  m;
    logic [31:0] v;
    logic [2:0]  md;
    longint      lo;
    int          cnt;
    do_reset();
    // Random mantissas, read back straight after the write
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      m = rnd;
      bus(1'b1, 32'(MRFC_ADDR_MANTISSA), {24'hABCDEF, m}, 32'h0);
      bus(1'b0, 32'(MRFC_ADDR_MANTISSA), 32'h0, {24'h0, m});
      settle();
      chk("mant", rate_mantissa, {24'h0, m});
      chk("word", symbol_rate_word, (32'h100 + {24'h0, m}) << 12);
    end
    // Exponent extremes, the top one with the largest mantissa
    bus(1'b1, 32'(MRFC_ADDR_EXPONENT), 32'hFFFF_FFF0, 32'h0);
    bus(1'b0, 32'(MRFC_ADDR_EXPONENT), 32'h0, 32'h0);
    bus(1'b1, 32'(MRFC_ADDR_MANTISSA), 32'h0000_00FF, 32'h0);
    bus(1'b1, 32'(MRFC_ADDR_EXPONENT), 32'hFFFF_FFFF, 32'h0);
    bus(1'b0, 32'(MRFC_ADDR_EXPONENT), 32'h0, 32'h0000_000F);
    settle();
    chk("exp", rate_exponent, 32'hF);
    chk("word_max", symbol_rate_word, 32'h00FF_8000);
    // Tick rate follows word over two to the accumulator width
    cnt = 0;
    for (int i = 0; i < 1000; i++) begin
      @(posedge clk_sys);
      if (symbol_tick === 1'b1) cnt++;
    end
    lo = (longint'(1000) * 64'h00FF_8000) >> FRAC_W;
    chk("ticks", 32'(cnt >= lo && cnt <= lo + 1), 32'h1);
    // Drop to a low rate first so that a bypass stays legal
    bus(1'b1, 32'(MRFC_ADDR_EXPONENT), 32'h0000_0008, 32'h0);
    settle();
    chk("word_low", symbol_rate_word, 32'h0001_FF00);
    // Each defined code twice, with bypass and biphase toggled alongside
    for (int c = 0; c < 8; c++) begin
      md = (c % 4 == 0) ? 3'h0 : (c % 4 == 1) ? 3'h1 : (c % 4 == 2) ? 3'h3 : 3'h7;
      v = {24'h0, c[2], md, c[0] ^ c[2], 3'h7};
      // Intermediate frequency sits outside this bank, so a bypass needs no retune here
      bus(1'b1, 32'(MRFC_ADDR_MODCTRL), v, 32'h0);
      bus(1'b0, 32'(MRFC_ADDR_MODCTRL), 32'h0, v & 32'hF8);
      settle();
      chk("bypass", dc_block_bypass, c[2]);
      chk("biphase", biphase_enable, c[0] ^ c[2]);
      chk("modsel", modulation_select, md);
      chk("decode", {mod_fsk2, mod_gfsk, mod_ook, mod_msk, modulation_defined},
          {md == 3'h0, md == 3'h1, md == 3'h3, md == 3'h7, 1'b1});
    end
    // Unmapped and misaligned accesses leave the bank alone
    bus(1'b1, 32'h0000_004C, 32'h0000_00FF, 32'h0);
    bus(1'b0, 32'h0000_004C, 32'h0, 32'h0);
    bus(1'b1, 32'(MRFC_ADDR_MANTISSA) + 32'h1, 32'h0000_0011, 32'h0);
    bus(1'b0, 32'(MRFC_ADDR_MANTISSA), 32'h0, 32'h0000_00FF);
    // Reset in mid-run restores every field
    do_reset();
    @(negedge clk_sys);
    chk("bypass_rst", dc_block_bypass, 32'h0);
    chk("biphase_rst", biphase_enable, 32'h0);
    repeat (4) @(posedge clk_sys);
    wrap_up();
  end
endmodule // mrfc_config_tb
`default_nettype wire
